// file: pkg/peak_limit_pkg.sv
// constants shared by the peak and over-limit detector
package peak_limit_pkg;
   // ==========================================
   // widths
   localparam int SAMPLE_W = 24;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int WIN_W = 8;

   // ==========================================
   // register word offsets on the register access port
   localparam logic [7:0] OFS_VOLT_PEAK = 8'h00;
   localparam logic [7:0] OFS_CURR_PEAK = 8'h01;
   localparam logic [7:0] OFS_WIN_LEN = 8'h02;
   localparam logic [7:0] OFS_VOLT_LVL = 8'h03;
   localparam logic [7:0] OFS_CURR_LVL = 8'h04;
   localparam logic [7:0] OFS_MEAS_MODE = 8'h05;
   localparam logic [7:0] OFS_EVT_FLAGS = 8'h06;
   localparam logic [7:0] OFS_EVT_ENABLE = 8'h07;
   localparam logic [7:0] OFS_PHASE_FLAGS = 8'h08;

   // ==========================================
   // field positions
   localparam int TAG_LSB = 24;
   localparam int SEL_LSB = 2;
   localparam int BIT_HIGH_CURRENT = 17;
   localparam int BIT_HIGH_VOLTAGE = 18;
   localparam int BIT_CURR_WIN_DONE = 23;
   localparam int BIT_VOLT_WIN_DONE = 24;
   localparam int PH_CURR_LSB = 3;
   localparam int PH_VOLT_LSB = 9;

   // ==========================================
   // reset values
   localparam logic [7:0] RST_WIN_LEN = 8'h00;
   localparam logic [23:0] RST_LEVEL = 24'h5A7540;
   localparam logic [7:0] RST_MEAS_MODE = 8'h00;
   localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
endpackage

// file: rtl/peak_tracker.sv
// running maximum of three phase magnitudes with per-window capture
`timescale 1ns/100ps
module peak_tracker #(
   parameter int W = 24
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // samples from the filter chain
   input wire logic sample_valid,
   input wire logic [W-1:0] sample_a,
   input wire logic [W-1:0] sample_b,
   input wire logic [W-1:0] sample_c,
   // window control
   input wire logic [2:0] phase_en,
   input wire logic window_end,
   input wire logic restart,
   // captured result
   output logic [W-1:0] peak_value_reg,
   output logic [2:0] peak_tag_reg
);
   // ==========================================
   // magnitudes
   logic [W-1:0] raw [3]; // signed samples per phase
   logic [W-1:0] mag [3]; // absolute values per phase
   assign raw[0] = sample_a;
   assign raw[1] = sample_b;
   assign raw[2] = sample_c;

   // two's complement magnitude; most negative code maps to 2^(W-1) unsigned
   for (genvar g = 0; g < 3; g++) begin : g_abs
      assign mag[g] = raw[g][W-1] ? W'(~raw[g] + 1'b1) : raw[g];
   end

   // ==========================================
   // candidate among enabled phases in this sample
   logic [W-1:0] cand_val; // largest enabled magnitude
   logic [2:0] cand_tag; // its phase, one-hot
   always_comb begin
      cand_val = '0;
      cand_tag = 3'h0;
      for (int i = 0; i < 3; i++) begin
         // strict compare keeps the earlier phase on a tie
         if (phase_en[i] && sample_valid && (cand_tag == 3'h0 || mag[i] > cand_val)) begin
            cand_val = mag[i];
            cand_tag = 3'(1 << i);
         end
      end
   end

   // ==========================================
   // running maximum within the open window
   logic [W-1:0] run_reg; // running maximum
   logic [2:0] run_tag_reg; // phase of running maximum
   wire take_cand = (cand_tag != 3'h0) && (run_tag_reg == 3'h0 || cand_val > run_reg);
   wire [W-1:0] merged_val = take_cand ? cand_val : run_reg;
   wire [2:0] merged_tag = take_cand ? cand_tag : run_tag_reg;

   // running maximum restarts at each window and on counter reset
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         run_reg <= '0;
         run_tag_reg <= 3'h0;
      end else if (restart || window_end) begin
         run_reg <= '0; // [R20]
         run_tag_reg <= 3'h0;
      end else if (take_cand) begin
         run_reg <= cand_val; // [R01]
         run_tag_reg <= cand_tag;
      end
   end

   // result changes only at window end and holds through the next window
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         peak_value_reg <= '0;
         peak_tag_reg <= 3'h0;
      end else if (window_end && !restart) begin
         peak_value_reg <= merged_val; // [R01] [R06]
         // one phase bit only; an empty window keeps the old tag
         if (merged_tag != 3'h0) begin
            peak_tag_reg <= merged_tag; // [R05]
         end
      end
   end
endmodule

// file: rtl/peak_limit_detect.sv
// peak and over-limit detector for three-phase voltage and current samples
// How it works
// R01 - track largest magnitude per channel, 24-bit peak
// R02 - window length counts half cycles from crossings
// R03 - mode bits 2..4 enable phases A..C
// R04 - every enabled phase crossing advances the counter
// R05 - peak tag bits 24..26 one-hot phase
// R06 - peak and tag update only at window end
// R07 - window end sets bit 23, maskable interrupt
// R08 - window end sets bit 24, maskable interrupt
// R09 - writing one clears flag, releases interrupt
// R10 - window-length write with phases selected restarts counter
// R11 - over-voltage sets bit 18 and phase bits
// R12 - mask bit 18 gates over-voltage interrupt
// R13 - clearing bit 18 clears voltage phase bits
// R14 - over-current sets bit 17, phase bits, interrupt
// R15 - clearing bit 17 clears current phase bits
// R16 - unsigned 24-bit limits against magnitudes
// R17 - zero limit detects continuously
// R18 - 24-bit values carried in 32-bit zero-padded words
// R19 - host reads phase flags before acknowledging
// R20 - running maximum restarts each window
// R21 - simultaneous phases all set their flags
`timescale 1ns/100ps
module peak_limit_detect (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // filtered samples, one strobe per sample period
   input wire logic sample_valid,
   input wire logic [peak_limit_pkg::SAMPLE_W-1:0] volt_a,
   input wire logic [peak_limit_pkg::SAMPLE_W-1:0] volt_b,
   input wire logic [peak_limit_pkg::SAMPLE_W-1:0] volt_c,
   input wire logic [peak_limit_pkg::SAMPLE_W-1:0] curr_a,
   input wire logic [peak_limit_pkg::SAMPLE_W-1:0] curr_b,
   input wire logic [peak_limit_pkg::SAMPLE_W-1:0] curr_c,
   // zero-crossing pulses per phase
   input wire logic zc_a,
   input wire logic zc_b,
   input wire logic zc_c,
   // register access port, one word per access
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [peak_limit_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [peak_limit_pkg::DATA_W-1:0] reg_wdata,
   output logic [peak_limit_pkg::DATA_W-1:0] reg_rdata,
   // interrupt line, low while an enabled flag is pending
   output logic interrupt_line_second_b
);
   import peak_limit_pkg::*;

   // register map, one word per offset
   //   0x00 voltage peak, read only
   //   0x01 current peak, read only
   //   0x02 window length
   //   0x03 voltage limit
   //   0x04 current limit
   //   0x05 mode
   //   0x06 event flags, write one
   //        to clear
   //   0x07 event enable mask
   //   0x08 phase flags
   //   others read zero
   //
   // event flag bits
   //   17 over-current
   //   18 over-voltage
   //   23 current window closed
   //   24 voltage window closed
   //
   // phase flag bits
   //   5..3 current, phase c..a
   //   11..9 voltage, phase c..a
   //
   // peak record
   //   23..0 magnitude
   //   26..24 one-hot phase
   //   31..27 zero
   //
   // widths
   //   samples 24, two's complement
   //   limits 24, unsigned
   //   window length 8
   //
   // reset values
   //   window length 0
   //   mode 0, mask 0
   //   limits 0x5A7540
   //   flags and peaks 0

   // ==========================================
   // write decode
   // strobes last as long as reg_wr
   // a held flag write clears again
   // unmapped writes vanish
   wire wr_win_len = reg_wr && (reg_addr == OFS_WIN_LEN);
   wire wr_volt_lvl = reg_wr && (reg_addr == OFS_VOLT_LVL);
   wire wr_curr_lvl = reg_wr && (reg_addr == OFS_CURR_LVL);
   wire wr_mode = reg_wr && (reg_addr == OFS_MEAS_MODE);
   wire wr_flags = reg_wr && (reg_addr == OFS_EVT_FLAGS);
   wire wr_enable = reg_wr && (reg_addr == OFS_EVT_ENABLE);

   // ==========================================
   // configuration registers
   logic [WIN_W-1:0] peak_window_length; // half cycles per window
   logic [SAMPLE_W-1:0] voltage_limit_level; // over-voltage threshold
   logic [SAMPLE_W-1:0] current_limit_level; // over-current threshold
   logic [7:0] measurement_mode_reg; // mode bits, phase select in 4..2
   logic [DATA_W-1:0] event_enable_second; // interrupt mask

   // software-written registers; only the low 24 bits of a limit word count
   // peak records have no write path
   // mode bits outside 4..2 are
   // stored but drive nothing
   // limit writes keep 23..0
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         peak_window_length <= RST_WIN_LEN;
         voltage_limit_level <= RST_LEVEL;
         current_limit_level <= RST_LEVEL;
         measurement_mode_reg <= RST_MEAS_MODE;
         event_enable_second <= RST_ENABLE;
      end else begin
         if (wr_win_len) begin
            peak_window_length <= reg_wdata[WIN_W-1:0]; // [R02]
         end
         if (wr_volt_lvl) begin
            voltage_limit_level <= reg_wdata[SAMPLE_W-1:0]; // [R18]
         end
         if (wr_curr_lvl) begin
            current_limit_level <= reg_wdata[SAMPLE_W-1:0]; // [R18]
         end
         if (wr_mode) begin
            measurement_mode_reg <= reg_wdata[7:0];
         end
         if (wr_enable) begin
            event_enable_second <= reg_wdata;
         end
      end
   end

   // ==========================================
   // half-cycle counter
   // one window for both channels
   // unselected crossings ignored
   // crossings in one cycle each count
   // a select-free length write
   // leaves the count running
   // walk, length two, a and b on:
   //   zc_a edge: count one
   //   zc_b edge: sum two, close
   //   next cycle: records, flags
   // spare top bit: three crossings
   // at a nonzero length never wrap
   // count clears at each close
   wire [2:0] peak_phase_select = measurement_mode_reg[SEL_LSB+2:SEL_LSB]; // [R03]
   wire [2:0] zc_hit = {zc_c, zc_b, zc_a} & peak_phase_select; // [R04]
   wire [1:0] zc_inc = 2'(zc_hit[0]) + 2'(zc_hit[1]) + 2'(zc_hit[2]);
   logic [WIN_W:0] half_cnt_reg; // half cycles seen in the open window
   wire [WIN_W:0] half_cnt_sum = half_cnt_reg + (WIN_W+1)'(zc_inc);
   // restart when window length is rewritten with any phase selected
   wire restart = wr_win_len && (peak_phase_select != 3'h0); // [R10]
   // a length of zero never closes a window
   wire window_end = !restart && (zc_inc != 2'h0) && (peak_window_length != '0)
                     && (half_cnt_sum >= {1'b0, peak_window_length}); // [R02]

   // counter clears to zero at each window end and on restart, dropping any excess count
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         half_cnt_reg <= '0;
      end else if (restart || window_end) begin
         half_cnt_reg <= '0; // [R10]
      end else begin
         half_cnt_reg <= half_cnt_sum; // [R04]
      end
   end

   // ==========================================
   // peak capture, one tracker per channel
   // a sample on the closing edge
   // lands in the closing window
   // an empty window reads zero
   // and keeps the old phase tag
   // restart clears the running
   // maximum and loads nothing
   // ties keep the earlier sample, then the lower phase
   // both trackers close together
   logic [SAMPLE_W-1:0] volt_peak_val; // captured voltage peak
   logic [2:0] voltage_peak_phase_tag; // phase of voltage peak
   logic [SAMPLE_W-1:0] curr_peak_val; // captured current peak
   logic [2:0] current_peak_phase_tag; // phase of current peak

   // voltage channel
   peak_tracker #(.W(SAMPLE_W)) u_volt_peak (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .sample_valid(sample_valid),
      .sample_a(volt_a),
      .sample_b(volt_b),
      .sample_c(volt_c),
      .phase_en(peak_phase_select),
      .window_end(window_end),
      .restart(restart),
      .peak_value_reg(volt_peak_val),
      .peak_tag_reg(voltage_peak_phase_tag)
   );

   // current channel
   peak_tracker #(.W(SAMPLE_W)) u_curr_peak (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .sample_valid(sample_valid),
      .sample_a(curr_a),
      .sample_b(curr_b),
      .sample_c(curr_c),
      .phase_en(peak_phase_select),
      .window_end(window_end),
      .restart(restart),
      .peak_value_reg(curr_peak_val),
      .peak_tag_reg(current_peak_phase_tag)
   );

   // tag above the 24-bit value, top bits zero
   wire [DATA_W-1:0] voltage_peak_record = {5'h00, voltage_peak_phase_tag, volt_peak_val}; // [R05]
   wire [DATA_W-1:0] current_peak_record = {5'h00, current_peak_phase_tag, curr_peak_val}; // [R05]

   // ==========================================
   // instantaneous over-limit compare
   // strict compare: a magnitude
   // equal to the limit is quiet
   // the most negative code reads
   // as 2^23, above full scale
   // only sample_valid cycles count
   // a zero limit fires every sample
   // limits compare unsigned
   logic [SAMPLE_W-1:0] vmag [3]; // voltage magnitudes
   logic [SAMPLE_W-1:0] imag [3]; // current magnitudes
   logic [SAMPLE_W-1:0] vraw [3]; // voltage samples
   logic [SAMPLE_W-1:0] iraw [3]; // current samples
   logic [2:0] high_voltage_hit; // phases over voltage limit now
   logic [2:0] high_current_hit; // phases over current limit now
   assign vraw[0] = volt_a;
   assign vraw[1] = volt_b;
   assign vraw[2] = volt_c;
   assign iraw[0] = curr_a;
   assign iraw[1] = curr_b;
   assign iraw[2] = curr_c;

   // every phase is compared on its own, so several may hit together
   for (genvar g = 0; g < 3; g++) begin : g_limit
      assign vmag[g] = vraw[g][SAMPLE_W-1] ? SAMPLE_W'(~vraw[g] + 1'b1) : vraw[g];
      assign imag[g] = iraw[g][SAMPLE_W-1] ? SAMPLE_W'(~iraw[g] + 1'b1) : iraw[g];
      // unsigned compare; only the most negative code exceeds a limit at full scale
      assign high_voltage_hit[g] = sample_valid && ((vmag[g] > voltage_limit_level)
                                   || (voltage_limit_level == '0)); // [R16] [R17] [R21]
      assign high_current_hit[g] = sample_valid && ((imag[g] > current_limit_level)
                                   || (current_limit_level == '0)); // [R16] [R17] [R21]
   end

   // ==========================================
   // event flags and phase flags
   // host sequence for an event:
   //   read event flags
   //   read phase flags or record
   //   write the bit back as one
   // a summary clear also clears
   // its three phase bits
   // window flags carry no phase
   // bits; the record tag does
   // other phase bits stay zero
   logic [DATA_W-1:0] event_flags_second; // sticky event flags
   logic [15:0] phase_event_flags; // sticky per-phase flags
   wire [DATA_W-1:0] flag_set = (DATA_W'(window_end) << BIT_CURR_WIN_DONE)
                              | (DATA_W'(window_end) << BIT_VOLT_WIN_DONE)
                              | (DATA_W'(high_current_hit != 3'h0) << BIT_HIGH_CURRENT)
                              | (DATA_W'(high_voltage_hit != 3'h0) << BIT_HIGH_VOLTAGE);
   // write one to clear
   wire [DATA_W-1:0] flag_clr = wr_flags ? reg_wdata : '0; // [R09]
   wire clr_hv = flag_clr[BIT_HIGH_VOLTAGE];
   wire clr_hc = flag_clr[BIT_HIGH_CURRENT];
   wire [15:0] phase_set = (16'(high_voltage_hit) << PH_VOLT_LSB)
                         | (16'(high_current_hit) << PH_CURR_LSB);
   wire [15:0] phase_clr = (16'({3{clr_hv}}) << PH_VOLT_LSB)
                         | (16'({3{clr_hc}}) << PH_CURR_LSB);

   // new events win over a clear in the same cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         event_flags_second <= '0;
         phase_event_flags <= '0;
      end else begin
         // [R07] [R08] [R11] [R14] [R09]
         event_flags_second <= (event_flags_second & ~flag_clr) | flag_set;
         // [R11] [R14] [R13] [R15]
         phase_event_flags <= (phase_event_flags & ~phase_clr) | phase_set;
      end
   end

   // ==========================================
   // interrupt line, low with any enabled flag pending
   // no register stage: the line
   // moves with the flags
   // a mask write alone can move it
   // hazard: an enabled zero limit
   // pulls the line low again on
   // each sample after a clear
   // [R07] [R08] [R12] [R14] [R09] [R15]
   assign interrupt_line_second_b = ~|(event_flags_second & event_enable_second);

   // ==========================================
   // read mux
   // narrow registers read
   // zero-extended
   // phase flags use bits 15..0
   logic [DATA_W-1:0] rd_mux; // selected register word
   always_comb begin
      case (reg_addr)
         OFS_VOLT_PEAK: rd_mux = voltage_peak_record;
         OFS_CURR_PEAK: rd_mux = current_peak_record;
         OFS_WIN_LEN: rd_mux = DATA_W'(peak_window_length);
         OFS_VOLT_LVL: rd_mux = DATA_W'(voltage_limit_level); // [R18]
         OFS_CURR_LVL: rd_mux = DATA_W'(current_limit_level); // [R18]
         OFS_MEAS_MODE: rd_mux = DATA_W'(measurement_mode_reg);
         OFS_EVT_FLAGS: rd_mux = event_flags_second;
         OFS_EVT_ENABLE: rd_mux = event_enable_second;
         OFS_PHASE_FLAGS: rd_mux = DATA_W'(phase_event_flags);
         default: rd_mux = '0;
      endcase
   end

   // read data registered one cycle after the strobe, held until next read
   // a read beside a write returns
   // the value before the write
   // nothing else moves it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end
endmodule

// file: bench/peak_limit_sva.sv
// port checker for the peak and over-limit detector
`timescale 1ns/100ps
module peak_limit_sva (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // sample and crossing strobes
   input wire logic sample_valid,
   input wire logic zc_a,
   input wire logic zc_b,
   input wire logic zc_c,
   // register access port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [peak_limit_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [peak_limit_pkg::DATA_W-1:0] reg_wdata,
   input wire logic [peak_limit_pkg::DATA_W-1:0] reg_rdata,
   // interrupt line
   input wire logic interrupt_line_second_b
);
   import peak_limit_pkg::*;
   // ==========================================
   // helpers
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // no event source active this cycle
   wire quiet = !sample_valid && !zc_a && !zc_b && !zc_c;
   wire rd_lvl = reg_rd && (reg_addr == OFS_VOLT_LVL || reg_addr == OFS_CURR_LVL);
   wire rd_pk = reg_rd && (reg_addr == OFS_VOLT_PEAK || reg_addr == OFS_CURR_PEAK);
   wire wr_flags = reg_wr && reg_addr == OFS_EVT_FLAGS;
   // ==========================================
   // assertions
   property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_lvl_pad; rd_lvl |=> reg_rdata[31:24] == 8'h00; endproperty
   a_lvl_pad: assert property (p_lvl_pad) else $error("limit pad not zero");
   property p_pk_fmt; rd_pk |=> reg_rdata[31:27] == 5'h00 && $onehot0(reg_rdata[26:24]); endproperty
   a_pk_fmt: assert property (p_pk_fmt) else $error("peak record malformed");
   property p_win_pad; reg_rd && reg_addr == OFS_WIN_LEN |=> reg_rdata[31:8] == 24'h0; endproperty
   a_win_pad: assert property (p_win_pad) else $error("window length wide");
   property p_mode_pad; reg_rd && reg_addr == OFS_MEAS_MODE |=> reg_rdata[31:8] == 24'h0; endproperty
   a_mode_pad: assert property (p_mode_pad) else $error("mode wide");
   property p_clear_all; wr_flags && reg_wdata == 32'hFFFFFFFF && quiet |=> interrupt_line_second_b;
   endproperty
   a_clear_all: assert property (p_clear_all) else $error("interrupt held after clear");
   property p_rise; $rose(interrupt_line_second_b) |-> $past(reg_wr) &&
      ($past(reg_addr) == OFS_EVT_FLAGS || $past(reg_addr) == OFS_EVT_ENABLE); endproperty
   a_rise: assert property (p_rise) else $error("interrupt released by itself");
   property p_fall; $fell(interrupt_line_second_b) |-> $past(sample_valid) || $past(zc_a) ||
      $past(zc_b) || $past(zc_c) || ($past(reg_wr) && $past(reg_addr) == OFS_EVT_ENABLE);
   endproperty
   a_fall: assert property (p_fall) else $error("interrupt without cause");
   // ==========================================
   // covers
   c_irq_low: cover property (!interrupt_line_second_b);
   c_phase_rd: cover property (reg_rd && reg_addr == OFS_PHASE_FLAGS);
   c_release: cover property ($rose(interrupt_line_second_b));
endmodule

bind peak_limit_detect peak_limit_sva chk (.core_clk, .rst_b, .sample_valid, .zc_a, .zc_b,
   .zc_c, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .interrupt_line_second_b);

// file: bench/testbench.sv
// self-checking bench for the peak and over-limit detector
`timescale 1ns/100ps
module testbench;
   import peak_limit_pkg::*;
   // ==========================================
   // design inputs, outputs and bench state
   logic core_clk = 1'b0, rst_b = 1'b0, sample_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic zc_a = 1'b0, zc_b = 1'b0, zc_c = 1'b0, rd_seen = 1'b0, irq_b;
   logic [23:0] v [3] = '{24'h0, 24'h0, 24'h0};
   logic [23:0] c [3] = '{24'h0, 24'h0, 24'h0};
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, pv, pc;
   logic [23:0] lim, vmax, cmax;
   logic [2:0] vtag, ctag;
   int bad_count = 0, check_count = 0;
   typedef struct {string name; logic [31:0] val;} note_s;
   note_s notes[$], nt;
   // expected reset contents, offsets 0 to 8 and one unmapped
   logic [31:0] rst_tab [10] = '{32'h0, 32'h0, {24'h0, RST_WIN_LEN}, {8'h0, RST_LEVEL},
      {8'h0, RST_LEVEL}, {24'h0, RST_MEAS_MODE}, 32'h0, RST_ENABLE, 32'h0, 32'h0};
   initial forever #5 core_clk = ~core_clk;
   peak_limit_detect dut (.core_clk(core_clk), .rst_b(rst_b), .sample_valid(sample_valid),
      .volt_a(v[0]), .volt_b(v[1]), .volt_c(v[2]), .curr_a(c[0]), .curr_b(c[1]),
      .curr_c(c[2]), .zc_a(zc_a), .zc_b(zc_b), .zc_c(zc_c), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .interrupt_line_second_b(irq_b));
   // ==========================================
   // shared tasks
   task automatic check(string name, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge core_clk) #1;
      reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
      @(posedge core_clk) #1;
      reg_wr = 1'b0;
   endtask
   // the note goes in first, the watcher pops it one cycle after the strobe
   task automatic rd(logic [7:0] a, logic [31:0] e, string n);
      notes.push_back('{n, e});
      @(posedge core_clk) #1;
      reg_rd = 1'b1; reg_addr = a;
      @(posedge core_clk) #1;
      reg_rd = 1'b0;
   endtask
   task automatic smp();
      @(posedge core_clk) #1 sample_valid = 1'b1;
      @(posedge core_clk) #1 sample_valid = 1'b0;
   endtask
   task automatic zc(logic [2:0] m);
      @(posedge core_clk) #1 {zc_c, zc_b, zc_a} = m;
      @(posedge core_clk) #1 {zc_c, zc_b, zc_a} = 3'b000;
   endtask
   task automatic irq(logic e);
      check("interrupt", {31'h0, e}, {31'h0, irq_b});
   endtask
   function automatic logic [23:0] mag(logic [23:0] x);
      return x[23] ? -x : x;
   endfunction
   // random sample within the filter range, either sign
   function automatic logic [23:0] rnd();
      logic [23:0] r;
      r = 24'($urandom_range(32'h5A7540));
      return $urandom_range(1) ? -r : r;
   endfunction
   // ==========================================
   // read watcher: compares the oldest note with the returned word
   always @(posedge core_clk) rd_seen <= reg_rd;
   always @(negedge core_clk) if (rd_seen === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      check(nt.name, nt.val, reg_rdata);
   end
   // watchdog
   initial begin
      #100us;
      bad_count++;
      complete_run();
   end
   // ==========================================
   // main sequence
   initial begin
      void'($urandom(32'hd7e58d43));
      repeat (12) @(posedge core_clk);
      #1 rst_b = 1'b1;
      irq(1'b1);
      foreach (rst_tab[i]) rd(8'(i), rst_tab[i], "reset value");
      wr(OFS_VOLT_PEAK, 32'hFFFFFFFF);
      rd(OFS_VOLT_PEAK, 32'h0, "read-only peak");
      wr(OFS_WIN_LEN, 32'hFFFFFF02);
      rd(OFS_WIN_LEN, 32'h02, "window length");
      wr(OFS_MEAS_MODE, 32'hFFFFFF0C);
      rd(OFS_MEAS_MODE, 32'h0C, "mode");
      $display("test registers done");
      // two windows on phases a and b, phase c busy but unselected
      wr(OFS_EVT_ENABLE, 32'h01800000);
      for (int w = 0; w < 2; w++) begin
         if (w == 0) zc(3'b001);
         if (w == 0) wr(OFS_WIN_LEN, 32'h2);
         vmax = 24'h0; cmax = 24'h0; vtag = 3'b001; ctag = 3'b001;
         for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 3; p++) begin
               v[p] = rnd();
               c[p] = rnd();
               if (p < 2 && mag(v[p]) > vmax) begin vmax = mag(v[p]); vtag = 3'b001 << p; end
               if (p < 2 && mag(c[p]) > cmax) begin cmax = mag(c[p]); ctag = 3'b001 << p; end
            end
            smp();
         end
         zc(3'b100);
         zc(3'b001);
         rd(OFS_EVT_FLAGS, 32'h0, "flags mid window");
         if (w == 1) rd(OFS_VOLT_PEAK, pv, "held voltage peak");
         if (w == 1) rd(OFS_CURR_PEAK, pc, "held current peak");
         zc(3'b010);
         pv = {5'h0, vtag, vmax};
         pc = {5'h0, ctag, cmax};
         irq(1'b0);
         rd(OFS_VOLT_PEAK, pv, "voltage peak");
         rd(OFS_CURR_PEAK, pc, "current peak");
         rd(OFS_EVT_FLAGS, 32'h01800000, "window flags");
         wr(OFS_EVT_FLAGS, 32'h01800000);
         irq(1'b1);
      end
      wr(OFS_MEAS_MODE, 32'h1C);
      wr(OFS_WIN_LEN, 32'h3);
      zc(3'b111);
      rd(OFS_EVT_FLAGS, 32'h01800000, "three phases");
      rd(OFS_VOLT_PEAK, {5'h0, vtag, 24'h0}, "empty window");
      wr(OFS_EVT_FLAGS, 32'h01800000);
      $display("test windows done");
      // over-limit on voltage b and c and on current c
      lim = 24'($urandom_range(32'h100000, 32'h10));
      wr(OFS_VOLT_LVL, {8'hFF, lim});
      wr(OFS_CURR_LVL, {8'hA5, lim});
      rd(OFS_VOLT_LVL, {8'h00, lim}, "voltage limit");
      rd(OFS_CURR_LVL, {8'h00, lim}, "current limit");
      wr(OFS_EVT_ENABLE, 32'h00060000);
      v = '{lim, -(lim + 24'h1), lim + 24'h1};
      c = '{-lim, 24'h0, lim + 24'h1};
      smp();
      irq(1'b0);
      rd(OFS_EVT_FLAGS, 32'h00060000, "limit flags");
      rd(OFS_PHASE_FLAGS, 32'h00000C20, "phase flags");
      wr(OFS_EVT_FLAGS, 32'h00040000);
      irq(1'b0);
      rd(OFS_PHASE_FLAGS, 32'h00000020, "phase after voltage clear");
      wr(OFS_EVT_FLAGS, 32'h00020000);
      irq(1'b1);
      rd(OFS_PHASE_FLAGS, 32'h0, "phase after current clear");
      wr(OFS_EVT_ENABLE, 32'h0);
      smp();
      irq(1'b1);
      rd(OFS_EVT_FLAGS, 32'h00060000, "masked flags");
      $display("test limits done");
      // zero limit fires on every sample, full-scale limit never
      wr(OFS_VOLT_LVL, 32'h0);
      wr(OFS_EVT_ENABLE, 32'h00040000);
      v = '{24'h0, 24'h0, 24'h0};
      c = '{24'h0, 24'h0, 24'h0};
      wr(OFS_EVT_FLAGS, 32'hFFFFFFFF);
      irq(1'b1);
      smp();
      irq(1'b0);
      wr(OFS_VOLT_LVL, {8'h00, RST_LEVEL});
      wr(OFS_EVT_FLAGS, 32'hFFFFFFFF);
      v = '{-RST_LEVEL, RST_LEVEL, -RST_LEVEL};
      smp();
      irq(1'b1);
      rd(OFS_EVT_FLAGS, 32'h0, "full-scale flags");
      $display("test level ends done");
      repeat (3) @(posedge core_clk);
      complete_run();
   end
endmodule
